/* verilog/aims_sequencer.sv */
// aims_sequencer: auxiliary i2c master stepping through four sensor channels once per sample tick
// assumes open-drain pads outside; sample tick and fifo sink are provided by the host device
`timescale 1ns/100ps
module aims_sequencer #(
	parameter int RATE_BITS = 5
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// sample timing
	input  wire logic        i_sample_tick,
	input  wire logic        i_internal_ready,
	output logic             o_data_ready,
	// fifo push of channel 3 bytes
	output logic             o_fifo_push,
	output logic      [7:0]  o_fifo_data,
	// aux bus pins, enable low while driving low
	input  wire logic        i_scl,
	output logic             o_scl,
	output logic             o_scl_oe_n,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe_n,
	// status
	output logic             o_busy,
	output logic             o_arb_lost
);
	// register state
	logic [7:0] mctl_q, mctl_d;
	logic [7:0] tgt_q [aims_pkg::NUM_CHAN];
	logic [7:0] tgt_d [aims_pkg::NUM_CHAN];
	logic [7:0] sreg_q [aims_pkg::NUM_CHAN];
	logic [7:0] sreg_d [aims_pkg::NUM_CHAN];
	logic [7:0] tctl_q [aims_pkg::NUM_CHAN];
	logic [7:0] tctl_d [aims_pkg::NUM_CHAN];
	logic [7:0] wbyte_q [aims_pkg::NUM_CHAN];
	logic [7:0] wbyte_d [aims_pkg::NUM_CHAN];
	logic [7:0] ext_q [aims_pkg::EXT_BYTES];
	logic [7:0] ext_d [aims_pkg::EXT_BYTES];
	logic [7:0] rsel_q, rsel_d;
	logic [RATE_BITS-1:0] rfac_q, rfac_d;
	logic [7:0] rdata_q, rdata_d;
	// sequencer state
	aims_pkg::aims_state_t st_q, st_d;
	aims_pkg::aims_phase_t ph_q, ph_d;
	logic [1:0] ch_q, ch_d;
	logic [3:0] left_q, left_d;
	logic [7:0] regp_q, regp_d;
	logic [4:0] wptr_q, wptr_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bit_q, bit_d;
	logic [1:0] qtr_q, qtr_d;
	logic [5:0] div_q, div_d;
	logic [RATE_BITS-1:0] rcnt_q, rcnt_d;
	logic last_rd_q, last_rd_d;
	logic first_q, first_d;
	logic pend_q, pend_d;
	logic scl_q, scl_d, sda_q, sda_d;
	logic arb_q, arb_d;
	logic dr_q, dr_d;
	logic push_q, push_d;
	logic [7:0] fdat_q, fdat_d;
	logic hold_q, hold_d;
	logic irdy_q, irdy_d;
	logic [7:0] held_q, held_d;
	logic [5:0] div_top;
	logic tick;

	// divider end value from the clock code, quarter bit per tick
	function automatic logic [5:0] div_of(input logic [3:0] code);
		if (code >= aims_pkg::CODE_HIGH_MIN) begin
			div_of = 6'(aims_pkg::DIV_HIGH_BASE + {2'h0, code});
		end else begin
			div_of = 6'(aims_pkg::DIV_LOW_BASE + {2'h0, code});
		end
	endfunction

	// channel runs this cycle
	function automatic logic chan_due(input logic [7:0] ctl, input logic slow, input logic on_rate);
		chan_due = ctl[aims_pkg::TC_ENABLE] && (ctl[3:0] != 4'h0) && (!slow || on_rate);
	endfunction

	assign div_top = div_of(mctl_q[3:0]);
	assign tick = (div_q == 6'h00);

	always_comb begin
		logic [1:0] c;
		logic found;
		logic [4:0] slot;
		c = 2'h0;
		found = 1'b0;
		slot = 5'h00;
		mctl_d = mctl_q;
		tgt_d = tgt_q;
		sreg_d = sreg_q;
		tctl_d = tctl_q;
		wbyte_d = wbyte_q;
		ext_d = ext_q;
		rsel_d = rsel_q;
		rfac_d = rfac_q;
		rdata_d = aims_pkg::RESET_BYTE;
		st_d = st_q;
		ph_d = ph_q;
		ch_d = ch_q;
		left_d = left_q;
		regp_d = regp_q;
		wptr_d = wptr_q;
		sh_d = sh_q;
		bit_d = bit_q;
		qtr_d = qtr_q;
		div_d = tick ? div_top : 6'(div_q - 6'h01);
		rcnt_d = rcnt_q;
		last_rd_d = last_rd_q;
		first_d = first_q;
		pend_d = pend_q;
		scl_d = scl_q;
		sda_d = sda_q;
		arb_d = arb_q;
		dr_d = 1'b0;
		push_d = 1'b0;
		fdat_d = fdat_q;
		hold_d = hold_q;
		held_d = held_q;
		irdy_d = irdy_q && mctl_q[aims_pkg::MC_WAIT_EXT];
		// register writes
		if (i_reg_wr) begin
			if (i_reg_addr == aims_pkg::ADDR_MASTER_CONTROL) mctl_d = i_reg_wdata;
			if (i_reg_addr == aims_pkg::ADDR_RATE_SELECT) rsel_d = i_reg_wdata;
			if (i_reg_addr == aims_pkg::ADDR_RATE_FACTOR) rfac_d = i_reg_wdata[RATE_BITS-1:0];
			if (i_reg_addr == aims_pkg::ADDR_STATUS) arb_d = 1'b0;
			for (int k = 0; k < aims_pkg::NUM_CHAN; k++) begin
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_TARGET + aims_pkg::CHAN_STRIDE * k)) tgt_d[k] = i_reg_wdata;
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_START + aims_pkg::CHAN_STRIDE * k)) sreg_d[k] = i_reg_wdata;
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_CONTROL + aims_pkg::CHAN_STRIDE * k)) tctl_d[k] = i_reg_wdata;
				if (i_reg_addr == 8'(aims_pkg::ADDR_WRITE_BYTE0 + k)) wbyte_d[k] = i_reg_wdata;
			end
		end
		// register reads
		if (i_reg_rd) begin
			if (i_reg_addr == aims_pkg::ADDR_MASTER_CONTROL) rdata_d = mctl_q;
			if (i_reg_addr == aims_pkg::ADDR_RATE_SELECT) rdata_d = rsel_q;
			if (i_reg_addr == aims_pkg::ADDR_RATE_FACTOR) rdata_d = 8'(rfac_q);
			if (i_reg_addr == aims_pkg::ADDR_STATUS) rdata_d = {6'h00, arb_q, o_busy};
			for (int k = 0; k < aims_pkg::NUM_CHAN; k++) begin
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_TARGET + aims_pkg::CHAN_STRIDE * k)) rdata_d = tgt_q[k];
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_START + aims_pkg::CHAN_STRIDE * k)) rdata_d = sreg_q[k];
				if (i_reg_addr == 8'(aims_pkg::ADDR_CHAN0_CONTROL + aims_pkg::CHAN_STRIDE * k)) rdata_d = tctl_q[k];
				if (i_reg_addr == 8'(aims_pkg::ADDR_WRITE_BYTE0 + k)) rdata_d = wbyte_q[k];
			end
			for (int k = 0; k < aims_pkg::EXT_BYTES; k++) begin
				if (i_reg_addr == 8'(aims_pkg::ADDR_EXT_DATA_BASE + k)) rdata_d = ext_q[k];
			end
		end
		// a sample tick is remembered until the sequencer takes it
		if (i_sample_tick) pend_d = 1'b1;
		if (i_internal_ready && !mctl_q[aims_pkg::MC_WAIT_EXT]) dr_d = 1'b1;
		// internal ready seen before the run ends is kept, else the run would hang in wait
		if (i_internal_ready && mctl_q[aims_pkg::MC_WAIT_EXT]) irdy_d = 1'b1;
		case (st_q)
			aims_pkg::ST_IDLE: begin
				if (pend_q && !(mctl_q[aims_pkg::MC_MULTI_MASTER] && !(i_scl && i_sda))) begin
					pend_d = i_sample_tick;
					ch_d = 2'h0;
					wptr_d = 5'h00;
					last_rd_d = 1'b0;
					first_d = 1'b1;
					st_d = aims_pkg::ST_PICK;
				end
			end
			aims_pkg::ST_PICK: begin
				// first due channel at or after ch_q keeps the fixed order
				for (int k = aims_pkg::NUM_CHAN - 1; k >= 0; k--) begin
					if (k >= int'(ch_q) && chan_due(tctl_q[k], rsel_q[k], rcnt_q == '0)) begin
						c = 2'(k);
						found = 1'b1;
					end
				end
				if (found) begin
					ch_d = c;
					left_d = tctl_q[c][3:0];
					regp_d = sreg_q[c];
					hold_d = 1'b0;
					ph_d = tctl_q[c][aims_pkg::TC_SKIP_REG] ?
						(tgt_q[c][aims_pkg::TA_DIRECTION] ? aims_pkg::PH_ADDR_R : aims_pkg::PH_ADDR_W)
						: aims_pkg::PH_ADDR_W;
					// stop then start after a read unless repeated start allowed for read after read
					if (!first_q && last_rd_q &&
						(!tgt_q[c][aims_pkg::TA_DIRECTION] || mctl_q[aims_pkg::MC_STOP_READS])) begin
						st_d = aims_pkg::ST_STOP;
					end else begin
						st_d = aims_pkg::ST_START;
					end
					qtr_d = 2'h0;
				end else begin
					st_d = first_q ? aims_pkg::ST_IDLE : aims_pkg::ST_STOP;
					ch_d = 2'h0;
					if (!first_q) ph_d = aims_pkg::PH_DATA;
					if (first_q) st_d = aims_pkg::ST_DONE;
				end
			end
			aims_pkg::ST_START: begin
				if (tick) begin
					qtr_d = 2'(qtr_q + 2'h1);
					case (qtr_q)
						// sda rises while scl is low, so a repeated start keeps a full bit time
						2'h0: sda_d = 1'b1;
						2'h1: scl_d = 1'b1;
						2'h2: sda_d = 1'b0;
						default: begin
							scl_d = 1'b0;
							first_d = 1'b0;
							case (ph_q)
								aims_pkg::PH_ADDR_W: sh_d = {tgt_q[ch_q][6:0], tctl_q[ch_q][aims_pkg::TC_SKIP_REG] ? 1'b0 : 1'b0};
								default: sh_d = {tgt_q[ch_q][6:0], 1'b1};
							endcase
							bit_d = 4'h0;
							st_d = aims_pkg::ST_BYTE;
						end
					endcase
				end
			end
			aims_pkg::ST_BYTE: begin
				if (tick) begin
					qtr_d = 2'(qtr_q + 2'h1);
					case (qtr_q)
						2'h0: sda_d = (ph_q == aims_pkg::PH_DATA) ? 1'b1 : sh_q[7];
						2'h1: scl_d = 1'b1;
						2'h2: begin
							if (ph_q == aims_pkg::PH_DATA) begin
								sh_d = {sh_q[6:0], i_sda};
							end else if (mctl_q[aims_pkg::MC_MULTI_MASTER] && sda_q && !i_sda) begin
								arb_d = 1'b1;
								st_d = aims_pkg::ST_DONE;
							end else begin
								sh_d = {sh_q[6:0], 1'b0};
							end
						end
						default: begin
							scl_d = 1'b0;
							bit_d = 4'(bit_q + 4'h1);
							if (bit_q == 4'h7) st_d = aims_pkg::ST_ACK;
						end
					endcase
				end
			end
			aims_pkg::ST_ACK: begin
				if (tick) begin
					qtr_d = 2'(qtr_q + 2'h1);
					case (qtr_q)
						2'h0: sda_d = (ph_q == aims_pkg::PH_DATA) ? (left_q == 4'h1) : 1'b1;
						2'h1: scl_d = 1'b1;
						2'h2: begin
							if (ph_q == aims_pkg::PH_DATA) begin
								// word pair start when register parity matches grouping
								slot = wptr_q;
								if (tctl_q[ch_q][aims_pkg::TC_SWAP] && left_q > 4'h1 &&
									(regp_q[0] == tctl_q[ch_q][aims_pkg::TC_GROUPING]) && !hold_q) begin
									hold_d = 1'b1;
									held_d = sh_q;
								end else if (hold_q) begin
									if (wptr_q <= 5'(aims_pkg::EXT_BYTES)) ext_d[wptr_q - 5'h01] = sh_q;
									if (wptr_q < 5'(aims_pkg::EXT_BYTES)) ext_d[wptr_q] = held_q;
									hold_d = 1'b0;
								end else begin
									if (slot < 5'(aims_pkg::EXT_BYTES)) ext_d[slot] = sh_q;
								end
								if (wptr_q < 5'(aims_pkg::EXT_BYTES)) wptr_d = 5'(wptr_q + 5'h01);
								if (ch_q == 2'h3 && mctl_q[aims_pkg::MC_CHAN3_FIFO]) begin
									push_d = 1'b1;
									fdat_d = sh_q;
								end
							end else if (mctl_q[aims_pkg::MC_MULTI_MASTER] && i_sda && ph_q == aims_pkg::PH_ADDR_W) begin
								arb_d = arb_q;
							end
						end
						default: begin
							scl_d = 1'b0;
							bit_d = 4'h0;
							st_d = aims_pkg::ST_BYTE;
							case (ph_q)
								aims_pkg::PH_ADDR_W: begin
									if (tctl_q[ch_q][aims_pkg::TC_SKIP_REG]) begin
										ph_d = aims_pkg::PH_WDATA;
										sh_d = wbyte_q[ch_q];
									end else begin
										ph_d = aims_pkg::PH_REG;
										sh_d = regp_q;
									end
								end
								aims_pkg::PH_REG: begin
									if (tgt_q[ch_q][aims_pkg::TA_DIRECTION]) begin
										ph_d = aims_pkg::PH_ADDR_R;
										st_d = aims_pkg::ST_START; // repeated start to turn around
										qtr_d = 2'h0;
									end else begin
										ph_d = aims_pkg::PH_WDATA;
										sh_d = wbyte_q[ch_q];
									end
								end
								aims_pkg::PH_ADDR_R: ph_d = aims_pkg::PH_DATA;
								default: begin
									regp_d = 8'(regp_q + 8'h01);
									left_d = 4'(left_q - 4'h1);
									if (ph_q == aims_pkg::PH_WDATA) sh_d = wbyte_q[ch_q];
									if (left_q == 4'h1) begin
										last_rd_d = tgt_q[ch_q][aims_pkg::TA_DIRECTION];
										// write ends its own transaction with a stop
										st_d = (ph_q == aims_pkg::PH_WDATA) ? aims_pkg::ST_STOP : aims_pkg::ST_NEXT;
									end
								end
							endcase
						end
					endcase
				end
			end
			aims_pkg::ST_NEXT: begin
				ch_d = 2'(ch_q + 2'h1);
				st_d = (ch_q == 2'h3) ? aims_pkg::ST_STOP : aims_pkg::ST_PICK;
				if (ch_q == 2'h3) ph_d = aims_pkg::PH_DATA;
			end
			aims_pkg::ST_STOP: begin
				if (tick) begin
					qtr_d = 2'(qtr_q + 2'h1);
					case (qtr_q)
						2'h0: sda_d = 1'b0;
						2'h1: scl_d = 1'b1;
						2'h2: sda_d = 1'b1;
						default: begin
							last_rd_d = 1'b0;
							if (ph_q == aims_pkg::PH_WDATA) begin
								ch_d = 2'(ch_q + 2'h1);
								st_d = (ch_q == 2'h3) ? aims_pkg::ST_DONE : aims_pkg::ST_PICK;
							end else if (ph_q == aims_pkg::PH_DATA && left_q == 4'h0 && ch_q == 2'h0) begin
								st_d = aims_pkg::ST_DONE;
							end else if (left_q != 4'h0) begin
								st_d = aims_pkg::ST_START;
							end else begin
								st_d = (ch_q == 2'h0) ? aims_pkg::ST_DONE : aims_pkg::ST_PICK;
							end
							first_d = 1'b1;
						end
					endcase
				end
			end
			aims_pkg::ST_DONE: begin
				scl_d = 1'b1;
				sda_d = 1'b1;
				rcnt_d = (rcnt_q >= rfac_q) ? '0 : RATE_BITS'(rcnt_q + 1'b1);
				if (mctl_q[aims_pkg::MC_WAIT_EXT]) st_d = aims_pkg::ST_WAIT;
				else st_d = aims_pkg::ST_IDLE;
			end
			aims_pkg::ST_WAIT: begin
				if (i_internal_ready || irdy_q) begin
					dr_d = 1'b1;
					irdy_d = 1'b0;
					st_d = aims_pkg::ST_IDLE;
				end
			end
			default: st_d = aims_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mctl_q <= aims_pkg::RESET_BYTE;
			for (int k = 0; k < aims_pkg::NUM_CHAN; k++) begin
				tgt_q[k] <= aims_pkg::RESET_BYTE;
				sreg_q[k] <= aims_pkg::RESET_BYTE;
				tctl_q[k] <= aims_pkg::RESET_BYTE;
				wbyte_q[k] <= aims_pkg::RESET_BYTE;
			end
			for (int k = 0; k < aims_pkg::EXT_BYTES; k++) ext_q[k] <= aims_pkg::RESET_BYTE;
			rsel_q <= aims_pkg::RESET_BYTE;
			rfac_q <= '0;
			rdata_q <= aims_pkg::RESET_BYTE;
			st_q <= aims_pkg::ST_IDLE;
			ph_q <= aims_pkg::PH_ADDR_W;
			ch_q <= 2'h0;
			left_q <= 4'h0;
			regp_q <= 8'h00;
			wptr_q <= 5'h00;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			qtr_q <= 2'h0;
			div_q <= 6'h00;
			rcnt_q <= '0;
			last_rd_q <= 1'b0;
			first_q <= 1'b1;
			pend_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			arb_q <= 1'b0;
			dr_q <= 1'b0;
			push_q <= 1'b0;
			fdat_q <= 8'h00;
			hold_q <= 1'b0;
			held_q <= 8'h00;
			irdy_q <= 1'b0;
		end else begin
			mctl_q <= mctl_d;
			tgt_q <= tgt_d;
			sreg_q <= sreg_d;
			tctl_q <= tctl_d;
			wbyte_q <= wbyte_d;
			ext_q <= ext_d;
			rsel_q <= rsel_d;
			rfac_q <= rfac_d;
			rdata_q <= rdata_d;
			st_q <= st_d;
			ph_q <= ph_d;
			ch_q <= ch_d;
			left_q <= left_d;
			regp_q <= regp_d;
			wptr_q <= wptr_d;
			sh_q <= sh_d;
			bit_q <= bit_d;
			qtr_q <= qtr_d;
			div_q <= div_d;
			rcnt_q <= rcnt_d;
			last_rd_q <= last_rd_d;
			first_q <= first_d;
			pend_q <= pend_d;
			scl_q <= scl_d;
			sda_q <= sda_d;
			arb_q <= arb_d;
			dr_q <= dr_d;
			push_q <= push_d;
			fdat_q <= fdat_d;
			hold_q <= hold_d;
			held_q <= held_d;
			irdy_q <= irdy_d;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_data_ready = dr_q;
	assign o_fifo_push = push_q;
	assign o_fifo_data = fdat_q;
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_scl_oe_n = scl_q;
	assign o_sda_oe_n = sda_q;
	assign o_busy = (st_q != aims_pkg::ST_IDLE);
	assign o_arb_lost = arb_q;
endmodule

/* verilog/aims_pkg.sv */
// aims_pkg: register map, field positions, reset values and timing for the aux i2c sequencer
// assumes a byte-wide register port and one 10 MHz system clock
package aims_pkg;
	// register offsets (byte addresses of the register port)
	localparam logic [7:0] ADDR_MASTER_CONTROL = 8'h24;
	localparam logic [7:0] ADDR_CHAN0_TARGET   = 8'h25;
	localparam logic [7:0] ADDR_CHAN0_START    = 8'h26;
	localparam logic [7:0] ADDR_CHAN0_CONTROL  = 8'h27;
	localparam logic [7:0] ADDR_EXT_DATA_BASE  = 8'h49;
	localparam logic [7:0] ADDR_WRITE_BYTE0    = 8'h63;
	localparam logic [7:0] ADDR_RATE_SELECT    = 8'h67;
	localparam logic [7:0] ADDR_RATE_FACTOR    = 8'h68;
	localparam logic [7:0] ADDR_STATUS         = 8'h69;
	localparam int         CHAN_STRIDE         = 3;
	localparam int         NUM_CHAN            = 4;
	localparam int         EXT_BYTES           = 24;
	// master control fields
	localparam int MC_MULTI_MASTER = 7;
	localparam int MC_WAIT_EXT     = 6;
	localparam int MC_CHAN3_FIFO   = 5;
	localparam int MC_STOP_READS   = 4;
	// target address fields
	localparam int TA_DIRECTION = 7;
	// transfer control fields
	localparam int TC_ENABLE    = 7;
	localparam int TC_SWAP      = 6;
	localparam int TC_SKIP_REG  = 5;
	localparam int TC_GROUPING  = 4;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// timing: 8 MHz reference is approximated by one tick per system clock scaled by divider
	localparam int          SYS_CLK_KHZ   = 10000;
	localparam int          REF_CLK_KHZ   = 8000;
	localparam logic [5:0]  DIV_LOW_BASE  = 6'h17;
	localparam logic [5:0]  DIV_HIGH_BASE = 6'h07;
	localparam logic [3:0]  CODE_HIGH_MIN = 4'h9;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_PICK  = 4'b0001,
		ST_START = 4'b0010,
		ST_BYTE  = 4'b0011,
		ST_ACK   = 4'b0100,
		ST_STOP  = 4'b0101,
		ST_NEXT  = 4'b0110,
		ST_WAIT  = 4'b0111,
		ST_DONE  = 4'b1000
	} aims_state_t;
	// byte phases within a channel transaction
	typedef enum logic [2:0] {
		PH_ADDR_W = 3'b000,
		PH_REG    = 3'b001,
		PH_ADDR_R = 3'b010,
		PH_DATA   = 3'b011,
		PH_WDATA  = 3'b100
	} aims_phase_t;
endpackage

/* bench/aims_slave_model.sv */
// aims_slave_model: behavioural sensor slave on the aux bus, register pointer and 256-byte memory
// assumes pulled-up scl and sda wires built by the bench
`timescale 1ns/100ps
module aims_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// bus
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda_oe_n,
	// observation
	output int        o_stops,
	output int        o_hits
);
	logic [7:0] mem [0:255];
	logic [7:0] sh, ptr, tx;
	int         bitn;
	logic       act, ph, sel, rd, own, talk, first;
	initial begin
		o_sda_oe_n = 1'b1;
		o_stops = 0;
		o_hits = 0;
		act = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
	end
	always @(negedge i_sda) if (i_scl === 1'b1) begin
		act = 1'b1;
		ph = 1'b0;
		bitn = 0;
		talk = 1'b0;
		o_sda_oe_n = 1'b1;
	end
	always @(posedge i_sda) if (i_scl === 1'b1 && act) begin
		o_stops++;
		act = 1'b0;
		o_sda_oe_n = 1'b1;
	end
	always @(posedge i_scl) if (act) begin
		if (bitn < 8) begin
			sh = {sh[6:0], i_sda};
			bitn++;
			if (bitn == 8 && !ph) begin
				sel = sh[7:1] == ADDR;
				rd = sh[0];
				own = sel;
				ph = 1'b1;
				first = 1'b1;
				if (sel) o_hits++;
			end else if (bitn == 8) begin
				own = sel && !rd;
				if (own && !first) mem[ptr] = sh;
				if (own && !first) ptr++;
				if (own && first) ptr = sh;
				if (own) first = 1'b0;
			end
		end else begin
			bitn = 0;
			if (sel && rd && talk && i_sda === 1'b1) sel = 1'b0;
			else if (sel && rd) begin
				tx = mem[ptr];
				ptr++;
				talk = 1'b1;
			end
		end
	end
	// data and ack change only while scl is low
	always @(negedge i_scl) if (act) begin
		if (bitn == 8) o_sda_oe_n = !own;
		else if (talk && sel) o_sda_oe_n = tx[7 - bitn];
		else o_sda_oe_n = 1'b1;
	end
endmodule

/* bench/aims_chk.sv */
// aims_chk: port-level checks of the aux i2c sequencer, bound into it
// assumes the aims_pkg register map and a single clock domain
`timescale 1ns/100ps
module aims_chk (
	// clock and reset
	input wire logic       i_sys_clk,
	input wire logic       i_rst_n,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic       i_reg_wr,
	input wire logic       i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// timing, fifo, bus, status
	input wire logic       i_sample_tick,
	input wire logic       i_internal_ready,
	input wire logic       o_data_ready,
	input wire logic       o_fifo_push,
	input wire logic       o_scl_oe_n,
	input wire logic       o_sda_oe_n,
	input wire logic       o_busy,
	input wire logic       o_arb_lost
);
	logic [7:0] mc_q, mc_d;
	logic       pend_q, pend_d, scl_q;
	int         hold_q, hold_d, quarter;
	always_comb begin
		mc_d = mc_q;
		if (i_reg_wr && i_reg_addr == aims_pkg::ADDR_MASTER_CONTROL) mc_d = i_reg_wdata;
		pend_d = i_sample_tick || (pend_q && !o_busy);
		hold_d = (o_scl_oe_n != scl_q) ? 0 : ((hold_q < 1000) ? hold_q + 1 : hold_q);
		quarter = (mc_q[3:0] >= aims_pkg::CODE_HIGH_MIN) ? int'(mc_q[3:0]) + 8 : int'(mc_q[3:0]) + 24;
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mc_q <= 8'h00;
			pend_q <= 1'b0;
			scl_q <= 1'b1;
			hold_q <= 0;
		end else begin
			mc_q <= mc_d;
			pend_q <= pend_d;
			scl_q <= o_scl_oe_n;
			hold_q <= hold_d;
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_wr_rd(a);
		i_reg_wr && i_reg_addr == a ##1 i_reg_rd && i_reg_addr == a;
	endsequence
	a_rdata_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_target_readback: assert property (s_wr_rd(aims_pkg::ADDR_CHAN0_TARGET) |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("target address readback wrong");
	a_control_readback: assert property (s_wr_rd(aims_pkg::ADDR_CHAN0_CONTROL) |=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("transfer control readback wrong");
	a_master_read: assert property (i_reg_rd && i_reg_addr == aims_pkg::ADDR_MASTER_CONTROL |=> o_reg_rdata == $past(mc_q))
		else $error("master control readback wrong");
	a_idle_released: assert property (!o_busy |-> o_scl_oe_n && o_sda_oe_n)
		else $error("bus driven while idle");
	a_busy_by_tick: assert property ($rose(o_busy) |-> pend_q)
		else $error("run started without a sample tick");
	a_fifo_gated: assert property (o_fifo_push |-> mc_q[aims_pkg::MC_CHAN3_FIFO] && $past(o_busy))
		else $error("fifo push without fifo bit or run");
	a_ready_waits: assert property (mc_q[aims_pkg::MC_WAIT_EXT] && o_busy |-> !o_data_ready)
		else $error("data ready during run with wait bit");
	a_ready_prompt: assert property (!mc_q[aims_pkg::MC_WAIT_EXT] && !o_busy && i_internal_ready |-> ##[1:2] o_data_ready)
		else $error("data ready missing");
	a_scl_hold: assert property ($changed(o_scl_oe_n) |-> hold_q >= quarter - 1)
		else $error("scl level shorter than a quarter bit");
	a_arb_clear: assert property (i_reg_wr && i_reg_addr == aims_pkg::ADDR_STATUS |=> !o_arb_lost)
		else $error("arbitration flag not cleared");
endmodule

bind aims_sequencer aims_chk u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_sample_tick(i_sample_tick),
	.i_internal_ready(i_internal_ready), .o_data_ready(o_data_ready), .o_fifo_push(o_fifo_push),
	.o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy), .o_arb_lost(o_arb_lost)
);

/* bench/tb_top.sv */
// tb_top: register-port driven test of the aux i2c sequencer against a sensor slave model
// assumes pull-ups on both bus wires and the aims_pkg register map
`timescale 1ns/100ps
module tb_top;
	logic       sys_clk = 1'b0;
	logic       rst_n, reg_wr, reg_rd, tick, iready;
	logic [7:0] reg_addr, reg_wdata, rdata, fifo_data, last_fifo, v;
	logic       data_ready, fifo_push, scl_o, scl_oe_n, sda_o, sda_oe_n, busy, arb_lost, slv_oe_n;
	int         errors, comparisons, ready_cnt, push_cnt, stops, hits, cyc, last_rise, min_per, dh, ds, h;
	wire logic  scl_w = scl_oe_n ? 1'b1 : scl_o;
	wire logic  sda_w = (sda_oe_n ? 1'b1 : sda_o) & slv_oe_n;
	logic [7:0] order [6] = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h02, 8'h01};
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (data_ready === 1'b1) ready_cnt++;
		if (fifo_push === 1'b1) push_cnt++;
		if (fifo_push === 1'b1) last_fifo = fifo_data;
	end
	always @(posedge scl_w) begin
		if (cyc - last_rise < min_per) min_per = cyc - last_rise;
		last_rise = cyc;
	end
	aims_sequencer u_dut (
		.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_sample_tick(tick),
		.i_internal_ready(iready), .o_data_ready(data_ready), .o_fifo_push(fifo_push),
		.o_fifo_data(fifo_data), .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe_n(scl_oe_n), .i_sda(sda_w),
		.o_sda(sda_o), .o_sda_oe_n(sda_oe_n), .o_busy(busy), .o_arb_lost(arb_lost)
	);
	aims_slave_model u_slave (.i_scl(scl_w), .i_sda(sda_w), .o_sda_oe_n(slv_oe_n), .o_stops(stops), .o_hits(hits));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = rdata;
	endtask
	// write then read back with no gap
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic cfg(input int k, input logic [7:0] t, input logic [7:0] r, input logic [7:0] c);
		logic [7:0] b;
		b = aims_pkg::ADDR_CHAN0_TARGET + 8'(3 * k);
		wr(b, t);
		wr(b + 8'h01, r);
		wr(b + 8'h02, c);
	endtask
	// one sample period: tick, then bounded wait for the run to end
	task automatic run(output int d_hits, output int d_stops);
		int h0, s0, n;
		h0 = hits;
		s0 = stops;
		min_per = 100000;
		@(posedge sys_clk);
		tick <= 1'b1;
		@(posedge sys_clk);
		tick <= 1'b0;
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		if (busy !== 1'b1) n = 40000;
		while (busy !== 1'b0 && n < 40000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 40000) begin
			errors++;
			$display("mismatch at %0t: run did not start or finish", $time);
			end_of_test();
		end
		d_hits = hits - h0;
		d_stops = stops - s0;
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, tick, iready} = 5'b0_0000;
		{reg_addr, reg_wdata} = 16'h0000;
		{errors, comparisons, ready_cnt, push_cnt, cyc, last_rise} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int a = 8'h24; a <= 8'h30; a++) begin
			rd(8'(a), v);
			check(v, aims_pkg::RESET_BYTE);
		end
		for (int a = 8'h63; a <= 8'h70; a++) begin
			rd(8'(a), v);
			check(v, aims_pkg::RESET_BYTE);
		end
		for (int k = 0; k < 4; k++) begin
			wrrd(aims_pkg::ADDR_CHAN0_TARGET + 8'(3 * k), 8'h80 | 8'(k), v);
			check(v, 8'h80 | 8'(k));
			wrrd(aims_pkg::ADDR_CHAN0_START + 8'(3 * k), 8'hf0 + 8'(k), v);
			check(v, 8'hf0 + 8'(k));
			wrrd(aims_pkg::ADDR_CHAN0_CONTROL + 8'(3 * k), 8'h70 | 8'(k), v);
			check(v, 8'h70 | 8'(k));
		end
		wrrd(aims_pkg::ADDR_MASTER_CONTROL, 8'h0f, v);
		check(v, 8'h0f);
		wrrd(aims_pkg::ADDR_STATUS, 8'h02, v);
		check(v, 8'h00);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'h00);
		@(posedge sys_clk);
		iready <= 1'b1;
		@(posedge sys_clk);
		iready <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check(ready_cnt, 1);
		// short channels keep every run inside one sample period
		cfg(0, 8'haa, 8'h01, 8'hc4);
		cfg(1, 8'haa, 8'h01, 8'hd2);
		run(dh, ds);
		check(dh, 4);
		check(ds, 1);
		check(min_per, 96);
		for (int i = 0; i < 6; i++) begin
			rd(aims_pkg::ADDR_EXT_DATA_BASE + 8'(i), v);
			check(v, order[i] ^ 8'ha5);
		end
		h = hits;
		repeat (300) @(posedge sys_clk);
		check(hits, h);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'h1f);
		run(dh, ds);
		check(ds, 2);
		check(min_per, 92);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'h00);
		cfg(1, 8'haa, 8'h01, 8'h80);
		cfg(2, 8'h2a, 8'h80, 8'h81);
		wr(aims_pkg::ADDR_WRITE_BYTE0 + 8'h02, 8'h3c);
		run(dh, ds);
		check(dh, 3);
		check(ds, 2);
		check(u_slave.mem[8'h80], 8'h3c);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'h20);
		cfg(0, 8'haa, 8'h01, 8'h00);
		cfg(2, 8'h2a, 8'h80, 8'h00);
		cfg(3, 8'haa, 8'h00, 8'ha1);
		run(dh, ds);
		check(dh, 1);
		check(push_cnt, 1);
		check(last_fifo, 8'h81 ^ 8'ha5);
		rd(aims_pkg::ADDR_EXT_DATA_BASE, v);
		check(v, 8'h81 ^ 8'ha5);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'h00);
		cfg(3, 8'haa, 8'h00, 8'h00);
		cfg(0, 8'haa, 8'h01, 8'h81);
		cfg(1, 8'haa, 8'h01, 8'h81);
		wr(aims_pkg::ADDR_RATE_FACTOR, 8'h01);
		wr(aims_pkg::ADDR_RATE_SELECT, 8'h02);
		for (int k = 0; k < 3; k++) begin
			run(dh, ds);
			check(dh, (k == 1) ? 2 : 4);
		end
		wr(aims_pkg::ADDR_RATE_SELECT, 8'h00);
		wr(aims_pkg::ADDR_MASTER_CONTROL, 8'hc0);
		h = ready_cnt;
		@(posedge sys_clk);
		iready <= 1'b1;
		@(posedge sys_clk);
		iready <= 1'b0;
		run(dh, ds);
		repeat (3) @(posedge sys_clk);
		check(ready_cnt - h, 1);
		check(dh, 4);
		check(arb_lost, 1'b0);
		end_of_test();
	end
endmodule
